/* dtad_defines.vh */
// Opcode patterns, field positions and class codes for the decoder
`ifndef DTAD_DEFINES_VH
`define DTAD_DEFINES_VH
`define DTAD_OP_SEG_LOAD   8'h8e
`define DTAD_OP_SEG_STORE  8'h8c
`define DTAD_OP_TABLE_TRANSLATE_OP       8'hd7
`define DTAD_OP_ADC_HI     6'h04
`define DTAD_OP_SUB_HI     6'h0a
`define DTAD_OP_IMM_HI     6'h20
`define DTAD_OP_DECADJ     8'h27
`define DTAD_OP_ASCADJ     8'h3f
`define DTAD_OP_BYTE_EXT   8'h98
`define DTAD_OP_WORD_EXT   8'h99
`define DTAD_BIT_D         1
`define DTAD_BIT_W         0
`define DTAD_BIT_S         1
`define DTAD_MODRM_B5      5
`define DTAD_MOD_HI        7
`define DTAD_MOD_LO        6
`define DTAD_REG_HI        5
`define DTAD_REG_LO        3
`define DTAD_RM_HI         2
`define DTAD_RM_LO         0
`define DTAD_RM_DIRECT     3'h6
`define DTAD_SW_WORD_IMM   2'h1
`define DTAD_LEN_OPCODE    3'h1
`define DTAD_CLS_NONE      4'h0
`define DTAD_CLS_SEG_LOAD  4'h1
`define DTAD_CLS_SEG_STORE 4'h2
`define DTAD_CLS_TABLE_TRANSLATE_OP      4'h3
`define DTAD_CLS_ADC       4'h4
`define DTAD_CLS_SUB       4'h5
`define DTAD_CLS_DECADJ    4'h6
`define DTAD_CLS_ASCADJ    4'h7
`define DTAD_CLS_BYTE_EXT  4'h8
`define DTAD_CLS_WORD_EXT  4'h9
`define DTAD_CLS_IMM_ARITH 4'ha
`define DTAD_CLS_ILLEGAL   4'hf
`endif

/* dtad_decoder.v */
// Data transfer and arithmetic opcode decoder, one instruction per request
// Contract
// - Byte 8e with addressing bit 5 clear loads a segment register from a register or memory operand.
// - Byte 8c with addressing bit 5 clear stores a segment register into a register or memory operand.
// - Byte d7 alone is a table lookup that replaces the low accumulator byte from memory.
// - Pattern 000100dw is add-with-carry with d choosing destination and w choosing width.
// - Pattern 001010dw is subtraction with d and w fields and an addressing byte.
// - Byte 27 alone is a packed decimal correction of the low accumulator byte after addition.
// - Byte 3f alone is an ASCII correction of the accumulator after subtraction.
// - Byte 98 alone sign-extends the low accumulator byte into the whole accumulator.
// - Byte 99 alone sign-extends the accumulator into the data register as a double word.
`include "dtad_defines.vh"
`default_nettype none
module dtad_decoder (
    input  wire        CORE_CLK,
    input  wire        RST_N,
    input  wire        VALID,
    input  wire [7:0]  OPCODE,
    input  wire [7:0]  MODRM,
    input  wire [7:0]  IMM_LO,
    input  wire [7:0]  IMM_HI,
    output reg         DONE,
    output reg  [3:0]  OP_CLASS,
    output reg         DIR_TO_REG,
    output reg         WIDE,
    output reg         USES_MODRM,
    output reg  [2:0]  MODRM_REG,
    output reg  [2:0]  INSN_LEN,
    output reg  [15:0] IMM_VALUE,
    output reg         SEG_LOAD_OP,
    output reg         SEG_STORE_OP
);

    // Displacement bytes implied by an addressing byte
    function [1:0] disp_len;
        input [7:0] m;
        begin
            case (m[`DTAD_MOD_HI:`DTAD_MOD_LO])
                2'h0:    disp_len = (m[`DTAD_RM_HI:`DTAD_RM_LO] == `DTAD_RM_DIRECT) ? 2'h2 : 2'h0;
                2'h1:    disp_len = 2'h1;
                2'h2:    disp_len = 2'h2;
                default: disp_len = 2'h0;
            endcase
        end
    endfunction

    // Segment move whose register field is accepted
    function seg_move_ok;
        input [7:0] op;
        input [7:0] m;
        input [7:0] pattern;
        begin
            seg_move_ok = (op == pattern) && !m[`DTAD_MODRM_B5];
        end
    endfunction

    // Register or memory form carrying d and w bits
    function dw_form;
        input [7:0] op;
        input [5:0] high_bits;
        begin
            dw_form = (op[7:2] == high_bits);
        end
    endfunction

    // Class of an opcode that stands alone
    function [3:0] single_class;
        input [7:0] op;
        begin
            case (op)
                `DTAD_OP_TABLE_TRANSLATE_OP:     single_class = `DTAD_CLS_TABLE_TRANSLATE_OP;
                `DTAD_OP_DECADJ:   single_class = `DTAD_CLS_DECADJ;
                `DTAD_OP_ASCADJ:   single_class = `DTAD_CLS_ASCADJ;
                `DTAD_OP_BYTE_EXT: single_class = `DTAD_CLS_BYTE_EXT;
                `DTAD_OP_WORD_EXT: single_class = `DTAD_CLS_WORD_EXT;
                default:           single_class = `DTAD_CLS_ILLEGAL;
            endcase
        end
    endfunction

    // Immediate bytes after the displacement
    function [1:0] imm_count;
        input [7:0] op;
        begin
            if (op[`DTAD_BIT_S:`DTAD_BIT_W] == `DTAD_SW_WORD_IMM) begin
                imm_count = 2'h2;
            end else begin
                imm_count = 2'h1;
            end
        end
    endfunction

    // Immediate operand as the execution side sees it
    function [15:0] imm_word;
        input [7:0] op;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (op[`DTAD_BIT_S:`DTAD_BIT_W] == `DTAD_SW_WORD_IMM) begin
                imm_word = {hi, lo};
            end else if (op[`DTAD_BIT_W]) begin
                imm_word = {{8{lo[7]}}, lo};
            end else begin
                imm_word = {8'h00, lo};
            end
        end
    endfunction

    reg  [3:0]  cls_d;
    reg         dir_d;
    reg         wide_d;
    reg         modrm_d;
    reg  [1:0]  imm_n_d;
    reg  [15:0] imm_d;
    wire [2:0]  len_d;

    always @* begin
        cls_d   = `DTAD_CLS_ILLEGAL;
        dir_d   = 1'h0;
        wide_d  = 1'h0;
        modrm_d = 1'h0;
        imm_n_d = 2'h0;
        imm_d   = 16'h0000;
        if (OPCODE == `DTAD_OP_SEG_LOAD) begin
            // Addressing byte counted even when refused
            modrm_d = 1'h1;
            if (seg_move_ok(OPCODE, MODRM, `DTAD_OP_SEG_LOAD)) begin
                cls_d  = `DTAD_CLS_SEG_LOAD;
                dir_d  = 1'h1;
                wide_d = 1'h1;
            end
        end else if (OPCODE == `DTAD_OP_SEG_STORE) begin
            modrm_d = 1'h1;
            if (seg_move_ok(OPCODE, MODRM, `DTAD_OP_SEG_STORE)) begin
                cls_d  = `DTAD_CLS_SEG_STORE;
                wide_d = 1'h1;
            end
        end else if (dw_form(OPCODE, `DTAD_OP_ADC_HI)) begin
            cls_d   = `DTAD_CLS_ADC;
            dir_d   = OPCODE[`DTAD_BIT_D];
            wide_d  = OPCODE[`DTAD_BIT_W];
            modrm_d = 1'h1;
        end else if (dw_form(OPCODE, `DTAD_OP_SUB_HI)) begin
            cls_d   = `DTAD_CLS_SUB;
            dir_d   = OPCODE[`DTAD_BIT_D];
            wide_d  = OPCODE[`DTAD_BIT_W];
            modrm_d = 1'h1;
        end else if (dw_form(OPCODE, `DTAD_OP_IMM_HI)) begin
            cls_d   = `DTAD_CLS_IMM_ARITH;
            wide_d  = OPCODE[`DTAD_BIT_W];
            modrm_d = 1'h1;
            imm_n_d = imm_count(OPCODE);
            imm_d   = imm_word(OPCODE, IMM_LO, IMM_HI);
        end else begin
            cls_d  = single_class(OPCODE);
            wide_d = (OPCODE == `DTAD_OP_WORD_EXT);
        end
    end

    assign len_d = `DTAD_LEN_OPCODE
                 + {2'h0, modrm_d}
                 + (modrm_d ? {1'h0, disp_len(MODRM)} : 3'h0)
                 + {1'h0, imm_n_d};

    // Results held until the next request
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DONE         <= 1'h0;
            OP_CLASS     <= `DTAD_CLS_NONE;
            DIR_TO_REG   <= 1'h0;
            WIDE         <= 1'h0;
            USES_MODRM   <= 1'h0;
            MODRM_REG    <= 3'h0;
            INSN_LEN     <= 3'h0;
            IMM_VALUE    <= 16'h0000;
            SEG_LOAD_OP  <= 1'h0;
            SEG_STORE_OP <= 1'h0;
        end else begin
            DONE <= VALID;
            if (VALID) begin
                OP_CLASS     <= cls_d;
                DIR_TO_REG   <= dir_d;
                WIDE         <= wide_d;
                USES_MODRM   <= modrm_d;
                MODRM_REG    <= MODRM[`DTAD_REG_HI:`DTAD_REG_LO];
                INSN_LEN     <= len_d;
                IMM_VALUE    <= imm_d;
                SEG_LOAD_OP  <= (cls_d == `DTAD_CLS_SEG_LOAD);
                SEG_STORE_OP <= (cls_d == `DTAD_CLS_SEG_STORE);
            end
        end
    end

endmodule // dtad_decoder
`default_nettype wire

/* dtad_partner.sv */
// Execution side model that counts completed decodes
`default_nettype none
module dtad_partner (
    input  wire logic CORE_CLK,
    input  wire logic RST_N,
    input  wire logic DONE,
    output var  int   n_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial n_done = 0;
    // One pulse per decode
    always @(posedge CORE_CLK) if (RST_N && DONE) n_done <= n_done + 1;
endmodule // dtad_partner
`default_nettype wire

/* dtad_asserts.sv */
// Concurrent checks on the decoder ports
`default_nettype none
module dtad_asserts (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        VALID,
    input wire logic        DONE,
    input wire logic        DIR_TO_REG,
    input wire logic        WIDE,
    input wire logic        USES_MODRM,
    input wire logic        SEG_LOAD_OP,
    input wire logic        SEG_STORE_OP,
    input wire logic [7:0]  OPCODE,
    input wire logic [7:0]  MODRM,
    input wire logic [7:0]  IMM_LO,
    input wire logic [3:0]  OP_CLASS,
    input wire logic [2:0]  INSN_LEN,
    input wire logic [15:0] IMM_VALUE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_seg_load: assert property (VALID&&OPCODE==8'h8e&&!MODRM[5] |=> SEG_LOAD_OP&&DIR_TO_REG) else $error("load");
    a_seg_store: assert property (VALID&&OPCODE==8'h8c&&!MODRM[5] |=> SEG_STORE_OP&&!DIR_TO_REG) else $error("store");
    a_table_translate_op_len: assert property (VALID&&OPCODE==8'hd7 |=> OP_CLASS==4'h3&&INSN_LEN==3'h1) else $error("table_translate_op");
    a_adc_fields: assert property (VALID&&OPCODE[7:2]==6'h04 |=> {DIR_TO_REG,WIDE}==$past(OPCODE[1:0])) else $error("adc");
    a_sub_modrm: assert property (VALID&&OPCODE[7:2]==6'h0a |=> OP_CLASS==4'h5&&USES_MODRM) else $error("sub");
    a_one_byte: assert property (VALID&&OPCODE inside {8'h27,8'h3f,8'h98,8'h99} |=> !USES_MODRM&&INSN_LEN==3'h1)
        else $error("len");
    a_imm_sext: assert property (VALID&&OPCODE==8'h83 |=> IMM_VALUE=={{8{$past(IMM_LO[7])}},$past(IMM_LO)}) else $error("imm");
    a_idle_hold: assert property (!VALID |=> !DONE&&$stable(INSN_LEN)) else $error("hold");
    c_load: cover property (VALID&&OPCODE==8'h8e);
    c_imm: cover property (VALID&&OPCODE==8'h81);
    c_back: cover property (VALID[*3]);
endmodule // dtad_asserts
bind dtad_decoder dtad_asserts u_chk (
    .CORE_CLK(CORE_CLK),
    .RST_N(RST_N),
    .VALID(VALID),
    .DONE(DONE),
    .DIR_TO_REG(DIR_TO_REG),
    .WIDE(WIDE),
    .USES_MODRM(USES_MODRM),
    .SEG_LOAD_OP(SEG_LOAD_OP),
    .SEG_STORE_OP(SEG_STORE_OP),
    .OPCODE(OPCODE),
    .MODRM(MODRM),
    .IMM_LO(IMM_LO),
    .OP_CLASS(OP_CLASS),
    .INSN_LEN(INSN_LEN),
    .IMM_VALUE(IMM_VALUE)
);
`default_nettype wire

/* dtad_decoder_tb_top.sv */
// Self-checking bench for the opcode decoder
`default_nettype none
module dtad_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 0, RST_N = 1, VALID = 0;
    logic [7:0] OPCODE = 0, MODRM = 0, IMM_LO = 0, IMM_HI = 0;
    wire DONE, DIR_TO_REG, WIDE, USES_MODRM, SEG_LOAD_OP, SEG_STORE_OP;
    wire [3:0] OP_CLASS;
    wire [2:0] INSN_LEN, MODRM_REG;
    wire [15:0] IMM_VALUE;
    logic [30:0] exp_q;
    logic pv_q;
    int seed = 65, n_fail = 0, n_tests = 0, n_req = 0, n_done, i;
    logic [7:0] tbl [13] = '{8'h8e,8'h8c,8'hd7,8'h13,8'h28,8'h27,8'h3f,8'h98,8'h99,8'h80,8'h81,8'h82,8'h83};
    always #12.5 CORE_CLK = ~CORE_CLK;
    dtad_decoder uut (
        .CORE_CLK(CORE_CLK),
        .RST_N(RST_N),
        .VALID(VALID),
        .OPCODE(OPCODE),
        .MODRM(MODRM),
        .IMM_LO(IMM_LO),
        .IMM_HI(IMM_HI),
        .DONE(DONE),
        .OP_CLASS(OP_CLASS),
        .DIR_TO_REG(DIR_TO_REG),
        .WIDE(WIDE),
        .USES_MODRM(USES_MODRM),
        .MODRM_REG(MODRM_REG),
        .INSN_LEN(INSN_LEN),
        .IMM_VALUE(IMM_VALUE),
        .SEG_LOAD_OP(SEG_LOAD_OP),
        .SEG_STORE_OP(SEG_STORE_OP)
    );
    dtad_partner eu (
        .CORE_CLK(CORE_CLK),
        .RST_N(RST_N),
        .DONE(DONE),
        .n_done(n_done)
    );
    function automatic logic [30:0] ref_f(input logic [7:0] o, m, l, h);
        logic [3:0] c;
        logic [2:0] n;
        logic [15:0] v;
        logic d, w, u;
        n = m[7:6]==2'h1 ? 3'h3 : (m[7:6]==2'h2 || m[7:6]==2'h0 && m[2:0]==3'h6) ? 3'h4 : 3'h2;
        c = 4'hf;
        v = 16'h0;
        d = 1'h0;
        w = 1'h0;
        u = 1'h1;
        casez (o)
            8'h8e: begin
                c = m[5] ? 4'hf : 4'h1;
                d = !m[5];
                w = !m[5];
            end
            8'h8c: begin
                c = m[5] ? 4'hf : 4'h2;
                w = !m[5];
            end
            8'b000100??: begin
                c = 4'h4;
                d = o[1];
                w = o[0];
            end
            8'b001010??: begin
                c = 4'h5;
                d = o[1];
                w = o[0];
            end
            8'b100000??: begin
                c = 4'ha;
                w = o[0];
                n = n + (o[1:0]==2'h1 ? 3'h2 : 3'h1);
                v = o[1:0]==2'h1 ? {h, l} : {{8{l[7] & o[0]}}, l};
            end
            default: begin
                n = 3'h1;
                u = 1'h0;
                w = o==8'h99;
                c = o==8'hd7 ? 4'h3 : o==8'h27 ? 4'h6 : o==8'h3f ? 4'h7 : o==8'h98 ? 4'h8 : o==8'h99 ? 4'h9 : 4'hf;
            end
        endcase
        return {c, n, v, d, w, u, m[5:3], c==4'h1, c==4'h2};
    endfunction
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            exp_q <= 0;
            pv_q <= 0;
        end else begin
            pv_q <= VALID;
            n_req <= n_req + VALID;
            if (VALID) exp_q <= ref_f(OPCODE, MODRM, IMM_LO, IMM_HI);
        end
    end
    always @(negedge CORE_CLK) if (RST_N) begin
        n_tests++;
        if ({DONE,OP_CLASS,INSN_LEN,IMM_VALUE,DIR_TO_REG,WIDE,USES_MODRM,MODRM_REG,SEG_LOAD_OP,SEG_STORE_OP} !== {pv_q,exp_q}) begin
            n_fail++;
            $display("mismatch %0t %h %h", $time,
                {DONE,OP_CLASS,INSN_LEN,IMM_VALUE,DIR_TO_REG,WIDE,USES_MODRM,MODRM_REG,SEG_LOAD_OP,SEG_STORE_OP}, {pv_q,exp_q});
        end
    end
    task end_sim;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #25000;
        n_fail++;
        end_sim;
    end
    initial begin
        RST_N <= 0;
        repeat (5) @(posedge CORE_CLK);
        RST_N <= 1;
        for (i = 0; i < 600; i++) begin
            @(posedge CORE_CLK);
            VALID <= i < 26 || $random(seed) % 4 != 0;
            OPCODE <= i < 26 ? tbl[i % 13] : $random(seed) % 2 ? tbl[$unsigned($random(seed)) % 13] : $random(seed);
            MODRM <= i < 13 ? 8'h06 : i < 26 ? 8'h26 : $random(seed);
            {IMM_HI, IMM_LO} <= $random(seed);
        end
        @(posedge CORE_CLK);
        VALID <= 0;
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 0;
        @(posedge CORE_CLK);
        RST_N <= 1;
        repeat (3) @(posedge CORE_CLK);
        n_tests++;
        if (n_done !== n_req) begin
            n_fail++;
            $display("mismatch %0t %h %h", $time, n_done, n_req);
        end
        end_sim;
    end
endmodule // dtad_decoder_tb_top
`default_nettype wire
